// File: verilog/line_alarm_consts.svh
// Offsets, field positions, reset values and timing counts of the alarm block
// Function
// (RL1) Set bit 0 latch when the driver-fail alarm changes state.
// (RL2) Set bit 1 latch when the receive signal-loss alarm changes state.
// (RL3) Set bit 2 latch when the receive lock-loss alarm changes state.
// (RL4) Set bit 3 latch when the jitter FIFO near-limit alarm changes.
// (RL5) Set bit 4 latch whenever the pattern checker reports a bit error.
// (RL6) Set bit 5 latch when the error counter reaches all ones.
// (RL7) Reading offset 0x02 returns the latches, then clears them.
// (RL8) Driver-fail alarm rises after 128 bit periods without a pulse.
// (RL9) Status bit 1 reads one while receive signal loss is declared.
// (RL10) Status bit 2 reads one while receive lock loss is declared.
// (RL11) Status bit 3 reads one while jitter FIFO is near its limit.
// (RL12) Status bit 4 reads one while analog signal loss is declared.
// (RL13) After reset both latch and status registers read zero.
// (RL14) A latch raises the interrupt only when its enable bit is one.
// (RL15) FIFO-limit enable is ignored while jitter attenuator is off.
// (RL16) An event coinciding with the clearing read leaves its latch set.
// (RL17) Interrupt stays high while any enabled latch is set.
`ifndef LINE_ALARM_CONSTS_SVH
`define LINE_ALARM_CONSTS_SVH

`define EVENT_LATCH_OFFSET  6'h02
`define ALARM_STATUS_OFFSET 6'h03
`define EVENT_LATCH_RESET   6'h00
`define ALARM_STATUS_RESET  5'h00
`define FIFO_LIMIT_BIT      3
`define COUNTER_FULL_VALUE  16'hffff
`define DM_SILENT_BITS      128

`endif

// File: verilog/line_alarm_pkg.sv
// Types shared by the alarm status block
package line_alarm_pkg;

    // Live alarm levels, bit 0 first from the right
    typedef struct packed {
        logic analog_signal_loss;
        logic jitter_fifo_near_limit;
        logic rx_lock_loss;
        logic rx_signal_loss;
        logic driver_fail_alarm;
    } alarm_t;

    // Change-latched event flags, bit 0 first from the right
    typedef struct packed {
        logic error_counter_full_latch;
        logic pattern_error_latch;
        logic fifo_limit_change_latch;
        logic rx_lock_loss_change_latch;
        logic rx_signal_loss_change_latch;
        logic driver_monitor_change_latch;
    } flags_t;

endpackage

// File: verilog/line_alarm_status_flags.sv
// Alarm level register, clear-on-read event latches and interrupt
`timescale 1ns/100ps
`include "line_alarm_consts.svh"

module line_alarm_status_flags
    import line_alarm_pkg::*;
#(
    parameter int SILENT_BITS = `DM_SILENT_BITS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        bit_strobe,
    input  wire logic        monitor_input_pos,
    input  wire logic        monitor_input_neg,
    input  wire logic        rx_signal_loss,
    input  wire logic        rx_lock_loss,
    input  wire logic        jitter_fifo_near_limit,
    input  wire logic        analog_signal_loss,
    input  wire logic        pattern_bit_error,
    input  wire logic [15:0] error_count,
    input  wire flags_t      irq_enable,
    input  wire logic        jitter_atten_on,
    input  wire logic        reg_rd,
    input  wire logic [5:0]  reg_addr,
    output logic      [7:0]  reg_rdata,
    output alarm_t           alarm_level_status,
    output flags_t           interrupt_event_latch,
    output logic             irq
);

    localparam int CW = $clog2(SILENT_BITS + 1);
    localparam logic [CW-1:0] SILENT_MAX = CW'(SILENT_BITS);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops

    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver monitor: count bit periods with no bipolar pulse

    logic [CW-1:0] silent_cnt;
    logic [CW-1:0] next_silent_cnt;
    logic          mon_pulse;

    assign mon_pulse = monitor_input_pos | monitor_input_neg;

    // Any pulse restarts, silence counts up and saturates
    always_comb begin
        next_silent_cnt = silent_cnt;
        if (mon_pulse) begin
            next_silent_cnt = '0;
        end else if (bit_strobe && silent_cnt != SILENT_MAX) begin
            next_silent_cnt = silent_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            silent_cnt <= '0;
        end else begin
            silent_cnt <= next_silent_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm levels and change events

    alarm_t      next_alarm;
    flags_t      evt;
    flags_t      next_latch;
    flags_t      eff_enable;
    logic        rd_latch;
    logic        rd_status;
    logic        cnt_full_d;
    logic        cnt_full_now;
    logic        next_irq;
    logic [7:0]  next_rdata;

    assign cnt_full_now = (error_count == `COUNTER_FULL_VALUE);
    assign rd_latch     = reg_rd && (reg_addr == `EVENT_LATCH_OFFSET);
    assign rd_status    = reg_rd && (reg_addr == `ALARM_STATUS_OFFSET);

    // Live levels taken straight from the line logic, driver alarm from the silence counter
    always_comb begin
        next_alarm.driver_fail_alarm      = (next_silent_cnt == SILENT_MAX); // [RL8]
        next_alarm.rx_signal_loss         = rx_signal_loss;          // [RL9]
        next_alarm.rx_lock_loss           = rx_lock_loss;            // [RL10]
        next_alarm.jitter_fifo_near_limit = jitter_fifo_near_limit;  // [RL11]
        next_alarm.analog_signal_loss     = analog_signal_loss;      // [RL12]
    end

    // One event bit per latch
    always_comb begin
        evt.driver_monitor_change_latch = next_alarm.driver_fail_alarm
            ^ alarm_level_status.driver_fail_alarm;               // [RL1]
        evt.rx_signal_loss_change_latch = next_alarm.rx_signal_loss
            ^ alarm_level_status.rx_signal_loss;                  // [RL2]
        evt.rx_lock_loss_change_latch   = next_alarm.rx_lock_loss
            ^ alarm_level_status.rx_lock_loss;                    // [RL3]
        evt.fifo_limit_change_latch     = next_alarm.jitter_fifo_near_limit
            ^ alarm_level_status.jitter_fifo_near_limit;          // [RL4]
        evt.pattern_error_latch         = pattern_bit_error;      // [RL5]
        evt.error_counter_full_latch    = cnt_full_now && !cnt_full_d; // [RL6]
    end

    // Clear on read, a coinciding event wins
    always_comb begin
        next_latch = interrupt_event_latch;
        if (rd_latch) begin
            next_latch = `EVENT_LATCH_RESET;                      // [RL7]
        end
        next_latch = next_latch | evt;                            // [RL16]
    end

    // FIFO-limit enable masked while the attenuator is off
    always_comb begin
        eff_enable = irq_enable;                                  // [RL14]
        eff_enable[`FIFO_LIMIT_BIT] = irq_enable[`FIFO_LIMIT_BIT]
            && jitter_atten_on;                                   // [RL15]
        next_irq = |(next_latch & eff_enable);                    // [RL17]
    end

    // Read data captured at the read, old latch value returned
    always_comb begin
        next_rdata = reg_rdata;
        if (rd_latch) begin
            next_rdata = {2'h0, interrupt_event_latch};           // [RL7]
        end else if (rd_status) begin
            next_rdata = {3'h0, alarm_level_status};
        end else if (reg_rd) begin
            next_rdata = 8'h00;
        end
    end

    // All registers of this group clear to zero
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            alarm_level_status    <= `ALARM_STATUS_RESET;         // [RL13]
            interrupt_event_latch <= `EVENT_LATCH_RESET;          // [RL13]
            cnt_full_d            <= 1'b0;
            irq                   <= 1'b0;
            reg_rdata             <= 8'h00;
        end else begin
            alarm_level_status    <= next_alarm;
            interrupt_event_latch <= next_latch;
            cnt_full_d            <= cnt_full_now;
            irq                   <= next_irq;
            reg_rdata             <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    flags_t eff_enable_q;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            eff_enable_q <= '0;
        end else begin
            eff_enable_q <= eff_enable;
        end
    end

    sequence latch_read_s;
        rd_latch && (evt == '0);
    endsequence

    sequence silence_done_s;
        bit_strobe && !mon_pulse && (silent_cnt == SILENT_MAX - CW'(1));
    endsequence

    drv_change_a: assert property ( // [RL1]
        @(posedge clk) disable iff (!rst_sync_b)
        $changed(alarm_level_status.driver_fail_alarm)
        |-> interrupt_event_latch.driver_monitor_change_latch)
        else $error("driver change not latched");

    sig_change_a: assert property ( // [RL2]
        @(posedge clk) disable iff (!rst_sync_b)
        $changed(alarm_level_status.rx_signal_loss)
        |-> interrupt_event_latch.rx_signal_loss_change_latch)
        else $error("signal loss change not latched");

    lock_change_a: assert property ( // [RL3]
        @(posedge clk) disable iff (!rst_sync_b)
        $changed(alarm_level_status.rx_lock_loss)
        |-> interrupt_event_latch.rx_lock_loss_change_latch)
        else $error("lock loss change not latched");

    fifo_change_a: assert property ( // [RL4]
        @(posedge clk) disable iff (!rst_sync_b)
        $changed(alarm_level_status.jitter_fifo_near_limit)
        |-> interrupt_event_latch.fifo_limit_change_latch)
        else $error("fifo limit change not latched");

    pattern_err_a: assert property ( // [RL5]
        @(posedge clk) disable iff (!rst_sync_b)
        pattern_bit_error |=> interrupt_event_latch.pattern_error_latch)
        else $error("pattern error not latched");

    counter_full_a: assert property ( // [RL6]
        @(posedge clk) disable iff (!rst_sync_b)
        cnt_full_now && !cnt_full_d
        |=> interrupt_event_latch.error_counter_full_latch)
        else $error("counter full not latched");

    read_clear_a: assert property ( // [RL7]
        @(posedge clk) disable iff (!rst_sync_b)
        latch_read_s |=> (interrupt_event_latch == '0)
        && (reg_rdata == {2'h0, $past(interrupt_event_latch)}))
        else $error("clear on read wrong");

    drv_silence_a: assert property ( // [RL8]
        @(posedge clk) disable iff (!rst_sync_b)
        silence_done_s ##1 !mon_pulse
        |=> alarm_level_status.driver_fail_alarm)
        else $error("driver alarm late");

    drv_pulse_a: assert property ( // [RL8]
        @(posedge clk) disable iff (!rst_sync_b)
        mon_pulse |=> !alarm_level_status.driver_fail_alarm [*1])
        else $error("driver alarm despite pulse");

    level_follow_a: assert property ( // [RL9] [RL10] [RL11] [RL12]
        @(posedge clk) disable iff (!rst_sync_b)
        $past(rst_sync_b) |-> alarm_level_status[4:1] == $past(
        {analog_signal_loss, jitter_fifo_near_limit,
         rx_lock_loss, rx_signal_loss}))
        else $error("status level mismatch");

    reset_zero_a: assert property ( // [RL13]
        @(posedge clk) !rst_sync_b |-> (interrupt_event_latch == '0)
        && (alarm_level_status == '0) && !irq)
        else $error("not zero in reset");

    keep_event_a: assert property ( // [RL16]
        @(posedge clk) disable iff (!rst_sync_b)
        rd_latch && (evt != '0)
        |=> (interrupt_event_latch == $past(evt)))
        else $error("event lost on read");

    irq_gate_a: assert property ( // [RL14] [RL15] [RL17]
        @(posedge clk) disable iff (!rst_sync_b)
        $past(rst_sync_b)
        |-> irq == |(interrupt_event_latch & eff_enable_q))
        else $error("interrupt gating wrong");

    // Read port, interrupt, cause and silence counter range checks
    rdata_hold_a: assert property ( // [RL7]
        @(posedge clk) disable iff (!rst_sync_b)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    status_read_a: assert property ( // [RL9] [RL10] [RL11] [RL12]
        @(posedge clk) disable iff (!rst_sync_b)
        rd_status |=> (reg_rdata == {3'h0, $past(alarm_level_status)}))
        else $error("status read wrong");

    status_no_clear_a: assert property ( // [RL7]
        @(posedge clk) disable iff (!rst_sync_b)
        rd_status && (evt == '0)
        |=> (interrupt_event_latch == $past(interrupt_event_latch)))
        else $error("status read disturbed latches");

    unmapped_zero_a: assert property ( // [RL7]
        @(posedge clk) disable iff (!rst_sync_b)
        reg_rd && !rd_latch && !rd_status |=> (reg_rdata == 8'h00))
        else $error("unmapped read not zero");

    irq_quiet_a: assert property ( // [RL17]
        @(posedge clk) disable iff (!rst_sync_b)
        (interrupt_event_latch == '0) |-> !irq)
        else $error("interrupt without latch");

    pattern_cause_a: assert property ( // [RL5]
        @(posedge clk) disable iff (!rst_sync_b)
        $rose(interrupt_event_latch.pattern_error_latch)
        |-> $past(pattern_bit_error))
        else $error("pattern latch set without error");

    silent_range_a: assert property ( // [RL8]
        @(posedge clk) disable iff (!rst_sync_b)
        silent_cnt <= SILENT_MAX)
        else $error("silence counter past its limit");

    full_cause_a: assert property ( // [RL6]
        @(posedge clk) disable iff (!rst_sync_b)
        $rose(interrupt_event_latch.error_counter_full_latch)
        |-> ($past(error_count) == `COUNTER_FULL_VALUE))
        else $error("full latch set without full count");

endmodule

// File: verif/line_alarm_host.sv
// Host model that issues register reads to the alarm block
`timescale 1ns/100ps

module line_alarm_host (
    input  wire logic       clk,
    output logic            reg_rd,
    output logic      [5:0] reg_addr,
    input  wire logic [7:0] reg_rdata
);
    // Idle strobe, address parked
    initial begin
        reg_rd = 1'b0;
        reg_addr = 6'h00;
    end

    // One read: strobe for one edge, data taken one cycle later
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a; // Released address does not hold its value
        #1;
        d = reg_rdata;
    endtask
endmodule

// File: verif/test_line_alarm_status_flags.sv
// Self-checking bench for the alarm status and event latch block
`timescale 1ns/100ps
`include "line_alarm_consts.svh"

module test_line_alarm_status_flags;
    import line_alarm_pkg::*;
    logic        clk, rst_b, bit_strobe, mon_p, mon_n, pbe, jat, irq;
    logic        reg_rd;
    logic [4:1]  lv;
    logic [15:0] ecnt;
    logic [5:0]  reg_addr;
    logic [7:0]  rdata, d;
    flags_t      ien, lat;
    alarm_t      lvl;
    int          num_errors, total_checks, n;

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    line_alarm_status_flags #(.SILENT_BITS(4)) uut (
        .clk(clk), .rst_b(rst_b), .bit_strobe(bit_strobe),
        .monitor_input_pos(mon_p), .monitor_input_neg(mon_n),
        .rx_signal_loss(lv[1]), .rx_lock_loss(lv[2]),
        .jitter_fifo_near_limit(lv[3]), .analog_signal_loss(lv[4]),
        .pattern_bit_error(pbe), .error_count(ecnt), .irq_enable(ien),
        .jitter_atten_on(jat), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(rdata), .alarm_level_status(lvl),
        .interrupt_event_latch(lat), .irq(irq));

    line_alarm_host host (
        .clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_rdata(rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset values and an unmapped offset
    task automatic t_reset;
        host.rd(`EVENT_LATCH_OFFSET, d);
        chk(d, 8'h00);
        host.rd(`ALARM_STATUS_OFFSET, d);
        chk(d, 8'h00);
        chk({1'b0, irq, lat}, 8'h00);
        host.rd(6'h01, d);
        chk(d, 8'h00);
    endtask

    // Each level input: status bit, change latch (none for analog signal loss), clear on read
    task automatic t_levels;
        for (int i = 1; i <= 4; i++) begin
            @(posedge clk);
            lv[i] <= 1'b1;
            cyc(1);
            chk({3'h0, lvl}, 8'h01 << i);
            host.rd(`ALARM_STATUS_OFFSET, d);
            chk(d, 8'h01 << i);
            host.rd(`EVENT_LATCH_OFFSET, d);
            chk(d, (i < 4) ? 8'h01 << i : 8'h00);
            chk({2'h0, lat}, 8'h00);
            @(posedge clk);
            lv[i] <= 1'b0;
            cyc(1);
            chk({3'h0, lvl}, 8'h00);
            chk({2'h0, lat}, (i < 4) ? 8'h01 << i : 8'h00);
            host.rd(`EVENT_LATCH_OFFSET, d);
        end
    endtask

    // Silent monitor raises the driver alarm, a pulse drops it
    task automatic t_monitor;
        @(posedge clk);
        bit_strobe <= 1'b1;
        mon_p <= 1'b0;
        cyc(3);
        chk({7'h0, lvl.driver_fail_alarm}, 8'h00);
        n = 0;
        while (lvl.driver_fail_alarm !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        if (n >= 10) begin
            num_errors++;
            $display("Error at %0t: driver alarm never rose", $time);
            stop_test();
        end
        chk({7'h0, n == 1}, 8'h01);
        host.rd(`EVENT_LATCH_OFFSET, d);
        chk(d, 8'h01);
        @(posedge clk);
        mon_n <= 1'b1;
        cyc(2);
        chk({7'h0, lvl.driver_fail_alarm}, 8'h00);
        chk({2'h0, lat}, 8'h01);
        @(posedge clk);
        bit_strobe <= 1'b0;
        mon_n <= 1'b0;
        host.rd(`EVENT_LATCH_OFFSET, d);
    endtask

    // Pattern error, counter full, event coinciding with the read
    task automatic t_pattern;
        @(posedge clk);
        pbe <= 1'b1;
        ecnt <= 16'hfffe;
        @(posedge clk);
        pbe <= 1'b0;
        cyc(1);
        chk({2'h0, lat}, 8'h10);
        @(posedge clk);
        ecnt <= `COUNTER_FULL_VALUE;
        cyc(1);
        chk({2'h0, lat}, 8'h30);
        fork
            host.rd(`EVENT_LATCH_OFFSET, d);
            begin
                @(posedge clk);
                pbe <= 1'b1;
                @(posedge clk);
                pbe <= 1'b0;
            end
        join
        chk(d, 8'h30);
        chk({2'h0, lat}, 8'h10);
        host.rd(`EVENT_LATCH_OFFSET, d);
        chk(d, 8'h10);
        chk({2'h0, lat}, 8'h00);
    endtask

    // Interrupt gating by enables and the attenuator
    task automatic t_irq;
        @(posedge clk);
        lv[3:2] <= 2'b11;
        ien <= 6'h08;
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        jat <= 1'b1;
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        @(posedge clk);
        ien <= 6'h00;
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        ien <= 6'h04;
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        host.rd(`EVENT_LATCH_OFFSET, d);
        chk({7'h0, irq}, 8'h00);
    endtask

    // Main sequence
    initial begin
        {rst_b, bit_strobe, mon_p, mon_n, pbe, jat} = 6'h00;
        lv = 4'h0;
        ecnt = 16'h0000;
        ien = 6'h00;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        cyc(3);
        t_reset();
        t_levels();
        t_monitor();
        t_pattern();
        t_irq();
        stop_test();
    end
endmodule
